// file: rtl/pser_pkg.sv
// Package of constants for the power state and local error status block.
package pser_pkg;

  // Function counts and field width of the power state vectors.
  localparam int PM_W = 3;
  localparam int PF_NUM = 4;
  localparam int VF_NUM = 252;

  // Function power state codes; every other code is reserved.
  localparam logic [2:0] PM_D0_UNINIT = 3'h0;
  localparam logic [2:0] PM_D0_ACTIVE = 3'h1;
  localparam logic [2:0] PM_D1 = 3'h2;
  localparam logic [2:0] PM_D3_HOT = 3'h4;

  // Link power state codes.
  localparam logic [1:0] LINK_L0 = 2'h0;
  localparam logic [1:0] LINK_TX_L0S = 2'h1;
  localparam logic [1:0] LINK_L1 = 2'h2;
  localparam logic [1:0] LINK_L23_READY = 2'h3;
  localparam logic [1:0] PHY_DL_UP = 2'h3;

  // Local error codes.
  localparam int ERR_W = 5;
  localparam int ERR_SRC_N = 32;
  localparam logic [4:0] ERR_NONE = 5'h00;
  localparam logic [4:0] ERR_PHY = 5'h01;
  localparam logic [4:0] ERR_REPLAY_TO = 5'h02;
  localparam logic [4:0] ERR_REPLAY_ROLL = 5'h03;
  localparam logic [4:0] ERR_BAD_TLP = 5'h04;
  localparam logic [4:0] ERR_BAD_DLLP = 5'h05;
  localparam logic [4:0] ERR_LINK_PROTO = 5'h06;
  localparam logic [4:0] ERR_REPLAY_COR = 5'h07;
  localparam logic [4:0] ERR_REPLAY_UNC = 5'h08;
  localparam logic [4:0] ERR_POSTED_COR = 5'h09;
  localparam logic [4:0] ERR_POSTED_UNC = 5'h0A;
  localparam logic [4:0] ERR_CPL_COR = 5'h0B;
  localparam logic [4:0] ERR_CPL_UNC = 5'h0C;
  localparam logic [4:0] ERR_OVF_POSTED = 5'h0D;
  localparam logic [4:0] ERR_OVF_NONPOSTED = 5'h0E;
  localparam logic [4:0] ERR_OVF_CPL = 5'h0F;
  localparam logic [4:0] ERR_FC_PROTO = 5'h10;
  localparam logic [4:0] ERR_TX_PARITY = 5'h11;
  localparam logic [4:0] ERR_UNEXP_CPL = 5'h12;
  localparam logic [4:0] ERR_CPL_TIMEOUT = 5'h13;
  localparam logic [4:0] ERR_REQ_STREAM_DROP = 5'h14;
  localparam logic [4:0] ERR_CPL_STREAM_DROP = 5'h16;
  localparam logic [4:0] ERR_USER_COR = 5'h17;
  localparam logic [4:0] ERR_USER_UNC = 5'h18;

  // Codes that carry a source; one bit per code.
  localparam logic [31:0] ERR_LEGAL_MASK = 32'h01DF_FFFE;
  // Priority per code, 0 highest; 31 marks a code with no source.
  localparam logic [4:0] ERR_PRIO [0:31] = '{
    5'h1F, 5'h10, 5'h0C, 5'h0D, 5'h0A, 5'h0B, 5'h09, 5'h16,
    5'h03, 5'h14, 5'h15, 5'h15, 5'h02, 5'h05, 5'h06, 5'h07,
    5'h08, 5'h0E, 5'h0F, 5'h11, 5'h12, 5'h1F, 5'h13, 5'h17,
    5'h17, 5'h1F, 5'h1F, 5'h1F, 5'h1F, 5'h1F, 5'h1F, 5'h1F};
  localparam logic [4:0] ERR_PRIO_NONE = 5'h1F;

  // Register byte offsets.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h04;
  localparam logic [7:0] REG_IRQ_MASK = 8'h08;
  localparam logic [7:0] REG_ERR_INFO = 8'h0C;
  localparam logic [7:0] REG_PF_STATE = 8'h10;
  localparam logic [7:0] REG_ERR_COUNT = 8'h14;

  // Control bits and reset values.
  localparam int CTRL_REPORT_EN = 0;
  localparam int CTRL_INJ_COR = 1;
  localparam int CTRL_INJ_UNC = 2;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam logic [3:0] IRQ_MASK_RESET = 4'h0;

  // Interrupt status bits.
  localparam int IRQ_W = 4;
  localparam int IRQ_LOCAL_ERR = 0;
  localparam int IRQ_PF_CHANGE = 1;
  localparam int IRQ_VF_CHANGE = 2;
  localparam int IRQ_LINK_CHANGE = 3;

  // Error information fields.
  localparam int INFO_LINK_LSB = 8;
  localparam int INFO_PHY_LSB = 12;
  localparam int ERR_CNT_W = 16;

  // Bus answers.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// file: rtl/pser_err_enc.sv
// Priority selector that picks one local error code out of concurrent sources.
`timescale 1ns/1ps
`default_nettype none
module pser_err_enc
  import pser_pkg::*;
(
  // Source bits, one per error code.
  input wire logic [ERR_SRC_N-1:0] err_src,
  // Winning code.
  output logic err_hit,
  output logic [ERR_W-1:0] err_code
);

  // Lowest priority value wins; a tie goes to the lower code since the test is strict.
  always_comb begin
    logic [4:0] best;
    best = ERR_PRIO_NONE;
    err_hit = 1'b0;
    err_code = ERR_NONE;
    for (int i = 1; i < ERR_SRC_N; i++) begin
      if (err_src[i] && ERR_LEGAL_MASK[i] && (ERR_PRIO[i] < best)) begin // [R5]
        best = ERR_PRIO[i];
        err_hit = 1'b1;
        err_code = 5'(i);
      end
    end
  end

endmodule
`default_nettype wire

// file: rtl/pser_top.sv
// Power state and local error status outputs with an AXI4-Lite register slave.
// How it works
// R1 - Twelve-bit PF state, three bits each.
// R2 - PF codes D0u, D0a, D1, D3hot only.
// R3 - 756-bit VF state, same codes, three each.
// R4 - Two-bit link state, valid when link up.
// R5 - Five-bit error code, lowest priority value wins.
// R6 - Link-layer error codes with their priorities.
// R7 - Memory ECC error codes with their priorities.
// R8 - Overflow and flow control error codes.
// R9 - Parity, unexpected completion, timeout codes.
// R10 - Packet drop codes; requester code distinct.
// R11 - User correctable and uncorrectable error codes.
// R12 - Consumer must not rely only on codes.
// R13 - Valid strobe lasts exactly one cycle.
// R14 - Outputs registered, reset to D0u and L0.
`timescale 1ns/1ps
`default_nettype none
module pser_top
  import pser_pkg::*;
#(
  parameter int PF_N = PF_NUM,
  parameter int VF_N = VF_NUM
)(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Power state from the configuration core.
  input wire logic [PF_N*PM_W-1:0] core_pf_state,
  input wire logic [VF_N*PM_W-1:0] core_vf_state,
  input wire logic [1:0] core_link_state,
  input wire logic [1:0] core_phy_link_status,
  // Error events from the core, one bit per code, pulsed.
  input wire logic [ERR_SRC_N-1:0] core_err_evt,
  // Errors signalled by user logic, pulsed.
  input wire logic user_err_cor,
  input wire logic user_err_unc,
  // Status outputs to user logic.
  output logic [PF_N*PM_W-1:0] func_power_state,
  output logic [VF_N*PM_W-1:0] virt_fn_power_state_vec,
  output logic [1:0] link_power_state,
  output logic [1:0] phy_link_status,
  output logic [ERR_W-1:0] local_error_out,
  output logic local_error_valid,
  // Interrupt.
  output logic irq,
  // AXI4-Lite write address.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data.
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address.
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data.
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // Accepts only the four documented state codes.
  function automatic logic pm_legal(input logic [2:0] code);
    pm_legal = (code == PM_D0_UNINIT) || (code == PM_D0_ACTIVE) ||
               (code == PM_D1) || (code == PM_D3_HOT);
  endfunction

  logic [PF_N*PM_W-1:0] pf_state_r;
  logic [PF_N*PM_W-1:0] pf_state_nxt;
  logic [VF_N*PM_W-1:0] vf_state_r;
  logic [VF_N*PM_W-1:0] vf_state_nxt;
  logic [1:0] link_state_r;
  logic [1:0] phy_status_r;
  logic [ERR_W-1:0] err_code_r;
  logic err_valid_r;
  logic [31:0] ctrl_r;
  logic [IRQ_W-1:0] irq_status_r;
  logic [IRQ_W-1:0] irq_mask_r;
  logic [IRQ_W-1:0] irq_event;
  logic [ERR_CNT_W-1:0] err_count_r;
  logic [ERR_SRC_N-1:0] err_src;
  logic err_hit;
  logic [ERR_W-1:0] err_code;
  logic inj_cor_r;
  logic inj_unc_r;

  // AXI bookkeeping.
  logic aw_held_r;
  logic w_held_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [31:0] rdata_r;
  logic wr_fire;
  logic wr_byte0;
  logic [31:0] rd_word;
  logic rd_hit;
  logic wr_hit;

  // Reserved codes from the core are dropped by holding the last legal state,
  // so the outputs never show a reserved value even if the core glitches.
  genvar f;
  generate
    for (f = 0; f < PF_N; f++) begin : g_pf
      assign pf_state_nxt[f*PM_W +: PM_W] = pm_legal(core_pf_state[f*PM_W +: PM_W]) ?
          core_pf_state[f*PM_W +: PM_W] : pf_state_r[f*PM_W +: PM_W]; // [R2]
    end
    for (f = 0; f < VF_N; f++) begin : g_vf
      assign vf_state_nxt[f*PM_W +: PM_W] = pm_legal(core_vf_state[f*PM_W +: PM_W]) ?
          core_vf_state[f*PM_W +: PM_W] : vf_state_r[f*PM_W +: PM_W]; // [R3]
    end
  endgenerate

  // Physical function power states, field f in bits [3f+2:3f].
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pf_state_r <= {PF_N{PM_D0_UNINIT}}; // [R14]
    end else begin
      pf_state_r <= pf_state_nxt; // [R1]
    end
  end

  // Virtual function power states.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vf_state_r <= {VF_N{PM_D0_UNINIT}}; // [R14]
    end else begin
      vf_state_r <= vf_state_nxt; // [R3]
    end
  end

  // Link power state and physical link status travel together, so a consumer
  // that checks for a completed data link sees both from the same cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_state_r <= LINK_L0; // [R14]
      phy_status_r <= 2'h0;
    end else begin
      link_state_r <= core_link_state; // [R4]
      phy_status_r <= core_phy_link_status;
    end
  end

  // Error sources by code; the user sources merge the port and software inject.
  always_comb begin
    err_src = core_err_evt & ERR_LEGAL_MASK;
    err_src[ERR_USER_COR] = user_err_cor | inj_cor_r; // [R11]
    err_src[ERR_USER_UNC] = user_err_unc | inj_unc_r; // [R11]
    if (!ctrl_r[CTRL_REPORT_EN]) begin
      err_src = '0;
    end
  end

  // Priority selection of concurrent errors.
  pser_err_enc u_enc (
    .err_src(err_src),
    .err_hit(err_hit),
    .err_code(err_code)
  ); // [R6] [R7] [R8] [R9] [R10]

  // One strobe per cycle with an error; losers of the same cycle are not
  // queued, which is why the consumer should also read the error registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_valid_r <= 1'b0;
      err_code_r <= ERR_NONE;
    end else begin
      err_valid_r <= err_hit; // [R13]
      if (err_hit) begin
        err_code_r <= err_code; // [R5]
      end
    end
  end

  // Saturating count of reported errors, a second witness beside the strobe.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_count_r <= '0;
    end else if (err_hit && (err_count_r != {ERR_CNT_W{1'b1}})) begin
      err_count_r <= err_count_r + 1'b1; // [R12]
    end
  end

  // Interrupt sources.
  assign irq_event[IRQ_LOCAL_ERR] = err_hit;
  assign irq_event[IRQ_PF_CHANGE] = |(pf_state_nxt ^ pf_state_r);
  assign irq_event[IRQ_VF_CHANGE] = |(vf_state_nxt ^ vf_state_r);
  assign irq_event[IRQ_LINK_CHANGE] = (core_link_state != link_state_r);

  // Write handshake: address and data are taken in either order and held.
  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready = !w_held_r && !bvalid_r;
  assign wr_fire = aw_held_r && w_held_r && !bvalid_r;
  assign wr_byte0 = wr_fire && w_strb_r[0];
  assign wr_hit = (aw_addr_r == REG_CTRL) || (aw_addr_r == REG_IRQ_STATUS) ||
                  (aw_addr_r == REG_IRQ_MASK) || (aw_addr_r == REG_ERR_INFO) ||
                  (aw_addr_r == REG_PF_STATE) || (aw_addr_r == REG_ERR_COUNT);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r <= 1'b1;
      aw_addr_r <= {s_axi_awaddr[7:2], 2'b00};
    end else if (wr_fire) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_r <= 1'b0;
    end
  end

  // Write response; unmapped addresses answer with a slave error.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Control register; inject bits self-clear into one-cycle pulses.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= CTRL_RESET;
      inj_cor_r <= 1'b0;
      inj_unc_r <= 1'b0;
    end else begin
      inj_cor_r <= 1'b0;
      inj_unc_r <= 1'b0;
      if (wr_byte0 && (aw_addr_r == REG_CTRL)) begin
        ctrl_r <= {31'h0000_0000, w_data_r[CTRL_REPORT_EN]};
        inj_cor_r <= w_data_r[CTRL_INJ_COR];
        inj_unc_r <= w_data_r[CTRL_INJ_UNC];
      end
    end
  end

  // Sticky status, write one to clear; a new event in the same cycle wins.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_r <= '0;
    end else if (wr_byte0 && (aw_addr_r == REG_IRQ_STATUS)) begin
      irq_status_r <= (irq_status_r & ~w_data_r[IRQ_W-1:0]) | irq_event;
    end else begin
      irq_status_r <= irq_status_r | irq_event;
    end
  end

  // Interrupt mask, one enables the matching status bit.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask_r <= IRQ_MASK_RESET;
    end else if (wr_byte0 && (aw_addr_r == REG_IRQ_MASK)) begin
      irq_mask_r <= w_data_r[IRQ_W-1:0];
    end
  end

  // Read mux.
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case ({s_axi_araddr[7:2], 2'b00})
      REG_CTRL: begin
        rd_word = ctrl_r;
      end
      REG_IRQ_STATUS: begin
        rd_word[IRQ_W-1:0] = irq_status_r;
      end
      REG_IRQ_MASK: begin
        rd_word[IRQ_W-1:0] = irq_mask_r;
      end
      REG_ERR_INFO: begin
        rd_word[ERR_W-1:0] = err_code_r;
        rd_word[INFO_LINK_LSB +: 2] = link_state_r;
        rd_word[INFO_PHY_LSB +: 2] = phy_status_r;
      end
      REG_PF_STATE: begin
        rd_word[PF_N*PM_W-1:0] = pf_state_r;
      end
      REG_ERR_COUNT: begin
        rd_word[ERR_CNT_W-1:0] = err_count_r;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // Read channel: one word answered on the cycle after the address is taken.
  assign s_axi_arready = !rvalid_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_word;
      rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // Outputs.
  assign func_power_state = pf_state_r; // [R1]
  assign virt_fn_power_state_vec = vf_state_r; // [R3]
  assign link_power_state = link_state_r; // [R4]
  assign phy_link_status = phy_status_r;
  assign local_error_out = err_code_r;
  assign local_error_valid = err_valid_r; // [R13]
  assign irq = |(irq_status_r & irq_mask_r);
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

endmodule
`default_nettype wire

// file: verification/pser_top_props.sv
// Checker of the status outputs against their inputs, bound into the top module.
`timescale 1ns/1ps
`default_nettype none
module pser_top_props
  import pser_pkg::*;
#(
  parameter int PF_N = PF_NUM,
  parameter int VF_N = VF_NUM
)(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Core side.
  input wire logic [PF_N*PM_W-1:0] core_pf_state,
  input wire logic [VF_N*PM_W-1:0] core_vf_state,
  input wire logic [1:0] core_link_state,
  input wire logic [1:0] core_phy_link_status,
  input wire logic [ERR_SRC_N-1:0] core_err_evt,
  // User side.
  input wire logic [PF_N*PM_W-1:0] func_power_state,
  input wire logic [VF_N*PM_W-1:0] virt_fn_power_state_vec,
  input wire logic [1:0] link_power_state,
  input wire logic [1:0] phy_link_status,
  input wire logic [ERR_W-1:0] local_error_out,
  input wire logic local_error_valid
);
  // True for the four power state codes that may reach a field.
  function automatic logic ok3(logic [2:0] c);
    return c inside {PM_D0_UNINIT, PM_D0_ACTIVE, PM_D1, PM_D3_HOT};
  endfunction

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Error reporting: legal codes, held between strobes, ECC fault over lower ranks.
  code_legal_a: assert property (local_error_valid |-> ERR_LEGAL_MASK[local_error_out])
    else $error("reported error code is reserved");
  code_hold_a: assert property (!local_error_valid |-> $stable(local_error_out))
    else $error("error code moved without a strobe");
  prio_win_a: assert property (local_error_valid && $past(core_err_evt[8])
    && !$past(core_err_evt[12]) |-> local_error_out == ERR_REPLAY_UNC)
    else $error("replay uncorrectable fault lost its precedence");
  // Power fields follow legal inputs one cycle later and ignore reserved ones.
  pf_follow_a: assert property ($past(aresetn) && ok3($past(core_pf_state[2:0]))
    |-> func_power_state[2:0] == $past(core_pf_state[2:0]))
    else $error("function 0 power state did not follow");
  pf_hold_a: assert property ($past(aresetn) && !ok3($past(core_pf_state[5:3]))
    |-> $stable(func_power_state[5:3]))
    else $error("reserved power code reached function 1");
  vf_follow_a: assert property ($past(aresetn) && ok3($past(core_vf_state[VF_N*3-1-:3]))
    |-> virt_fn_power_state_vec[VF_N*3-1-:3] == $past(core_vf_state[VF_N*3-1-:3]))
    else $error("last virtual function state did not follow");
  link_follow_a: assert property ($past(aresetn) |-> link_power_state ==
    $past(core_link_state) && phy_link_status == $past(core_phy_link_status))
    else $error("link state outputs did not follow");
  // Reset must clear the strobe, both power state vectors and the link power state whatever the inputs do.
  reset_idle_a: assert property (disable iff (1'b0) !aresetn |=> !local_error_valid
    && func_power_state == '0 && virt_fn_power_state_vec == '0 && link_power_state == LINK_L0)
    else $error("status outputs not at their idle values after reset");
endmodule

bind pser_top pser_top_props #(.PF_N(PF_N), .VF_N(VF_N)) u_props (.aclk, .aresetn,
  .core_pf_state, .core_vf_state, .core_link_state, .core_phy_link_status, .core_err_evt,
  .func_power_state, .virt_fn_power_state_vec, .link_power_state, .phy_link_status,
  .local_error_out, .local_error_valid);
`default_nettype wire

// file: verification/pser_user_model.sv
// Model of the user logic that consumes the status outputs.
`timescale 1ns/1ps
`default_nettype none
module pser_user_model
  import pser_pkg::*;
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Status from the block.
  input wire logic [ERR_W-1:0] local_error_out,
  input wire logic local_error_valid,
  input wire logic [1:0] link_power_state,
  input wire logic [1:0] phy_link_status,
  // What the user logic has gathered.
  output logic [15:0] seen_cnt,
  output logic [4:0] seen_code,
  output logic link_ok
);
  // The code is taken only under the strobe; software also reads the status registers,
  // so an error that loses to another in the same cycle and gets no strobe of its own does not hide the fault.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seen_cnt <= 16'h0000;
      seen_code <= ERR_NONE;
    end else if (local_error_valid) begin
      seen_cnt <= seen_cnt + 16'h0001;
      seen_code <= local_error_out;
    end
  end
  // The link power state is trusted only once data link setup is complete.
  assign link_ok = (phy_link_status == PHY_DL_UP);
endmodule
`default_nettype wire

// file: verification/pser_top_bench.sv
// Self-checking bench for the power state and local error status block.
`timescale 1ns/1ps
`default_nettype none
module pser_top_bench;
  import pser_pkg::*;
  logic aclk, aresetn, user_err_cor, user_err_unc, local_error_valid, irq, link_ok, en;
  logic [11:0] core_pf_state, func_power_state, pf_exp;
  logic [755:0] core_vf_state, virt_fn_power_state_vec, vf_exp;
  logic [767:0] vt;
  logic [1:0] core_link_state, core_phy_link_status, link_power_state, phy_link_status;
  logic [31:0] core_err_evt, s_axi_wdata, s_axi_rdata, rd, rv;
  logic [4:0] local_error_out, seen_code, last, bc, bp;
  logic [15:0] seen_cnt;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int n_errors, checks, seed, n_model, i, k;

  pser_top #(.PF_N(PF_NUM), .VF_N(VF_NUM)) dut (.*);
  pser_user_model peer (.*);

  // Free running 25 MHz clock.
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  // Bench-side view of the legal power codes.
  function automatic logic ok3(logic [2:0] c);
    return c == 3'h0 || c == 3'h1 || c == 3'h2 || c == 3'h4;
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (e !== g) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // A wait that ran out of cycles ends the run as a failure.
  task automatic tmo;
    if (k == 40) begin
      n_errors++;
      give_verdict();
    end
  endtask

  // One register write; each channel is held until its own ready is seen.
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    tmo();
    chk("bresp", er, s_axi_bresp);
    s_axi_bready <= 1'b0;
    #1;
  endtask

  task automatic axr(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    tmo();
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // One cycle of error sources; the model keeps the lowest rank, lower code on a tie.
  task automatic err(input logic [31:0] ev, input logic uc, input logic uu);
    @(posedge aclk);
    core_err_evt <= ev;
    user_err_cor <= uc;
    user_err_unc <= uu;
    @(posedge aclk);
    core_err_evt <= '0;
    user_err_cor <= 1'b0;
    user_err_unc <= 1'b0;
    #1;
    rv = (ev & ERR_LEGAL_MASK & 32'hFE7F_FFFF) | {7'h00, uu, uc, 23'h00_0000};
    bp = 5'h1F;
    for (i = 31; i >= 0; i--) if (rv[i] && ERR_PRIO[i] <= bp) {bp, bc} = {ERR_PRIO[i], 5'(i)};
    if (en && rv != 0) begin
      last = bc;
      n_model++;
    end
    chk("strobe", {31'h0, en && rv != 0}, {31'h0, local_error_valid});
    chk("code", {27'h0, last}, {27'h0, local_error_out});
    @(posedge aclk);
    #1;
    chk("strobe drop", 32'h0, {31'h0, local_error_valid});
  endtask

  initial begin
    {core_pf_state, core_vf_state, core_link_state, core_phy_link_status} = '0;
    {core_err_evt, user_err_cor, user_err_unc, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    s_axi_rready = 1'b0;
    s_axi_wstrb = 4'hF;
    {n_errors, checks, n_model, k} = '0;
    {pf_exp, vf_exp, last} = '0;
    en = 1'b1;
    seed = 67;
    aresetn = 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1;
    chk("pf idle", 32'h0, {20'h0, func_power_state});
    chk("irq idle", 32'h0, {31'h0, irq});
    // Register reset values, then an unmapped place.
    for (i = 0; i < 4; i++) begin
      axr(8'(i * 4));
      chk("reg reset", (i == 0) ? CTRL_RESET : 32'h0, rd);
    end
    axr(8'h40);
    chk("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    // Every documented code alone.
    for (int c = 1; c < 25; c++) begin
      if (ERR_LEGAL_MASK[c]) err(32'h1 << c, c == 23, c == 24);
    end
    // Concurrent errors of random mix.
    repeat (40) begin
      rv = $random(seed);
      err($random(seed), rv[0], rv[1]);
    end
    // Software inject pulses; both user codes share a rank, so the lower code wins the tie.
    axw(REG_CTRL, 32'h0000_0005, RESP_OKAY);
    chk("inject unc", {27'h1, ERR_USER_UNC}, {26'h0, local_error_valid, local_error_out});
    axw(REG_CTRL, 32'h0000_0007, RESP_OKAY);
    chk("inject tie", {27'h1, ERR_USER_COR}, {26'h0, local_error_valid, local_error_out});
    n_model += 2;
    last = ERR_USER_COR;
    axr(REG_ERR_COUNT);
    chk("err count", {16'h0, 16'(n_model)}, rd);
    chk("peer count", {16'h0, 16'(n_model)}, {16'h0, seen_cnt});
    chk("peer code", {27'h0, last}, {27'h0, seen_code});
    axr(REG_ERR_INFO);
    chk("info code", {27'h0, last}, rd & 32'h1F);
    // Interrupt: masked, unmasked, cleared, raised again.
    chk("irq masked", 32'h0, {31'h0, irq});
    axw(REG_IRQ_MASK, 32'h1, RESP_OKAY);
    chk("irq on", 32'h1, {31'h0, irq});
    axw(REG_IRQ_STATUS, 32'h1, RESP_OKAY);
    chk("irq cleared", 32'h0, {31'h0, irq});
    err(32'h0000_0040, 1'b0, 1'b0);
    chk("irq event", 32'h1, {31'h0, irq});
    axw(8'h44, 32'h0, RESP_SLVERR);
    // Reporting switched off swallows sources.
    axw(REG_CTRL, 32'h0, RESP_OKAY);
    en = 1'b0;
    err(32'h0000_1000, 1'b1, 1'b0);
    axw(REG_CTRL, 32'h1, RESP_OKAY);
    en = 1'b1;
    // Power and link states with random codes, reserved ones included.
    repeat (30) begin
      for (i = 0; i < 24; i++) vt[32*i+:32] = $random(seed);
      rv = $random(seed);
      @(posedge aclk);
      core_pf_state <= rv[11:0];
      core_vf_state <= vt[755:0];
      core_link_state <= rv[13:12];
      core_phy_link_status <= rv[15:14];
      @(posedge aclk);
      #1;
      for (i = 0; i < 4; i++) if (ok3(rv[3*i+:3])) pf_exp[3*i+:3] = rv[3*i+:3];
      for (i = 0; i < 252; i++) if (ok3(vt[3*i+:3])) vf_exp[3*i+:3] = vt[3*i+:3];
      chk("pf state", {20'h0, pf_exp}, {20'h0, func_power_state});
      chk("link", {28'h0, rv[15:12]}, {28'h0, phy_link_status, link_power_state});
      chk("link ok", {31'h0, rv[15:14] == 2'h3}, {31'h0, link_ok});
      checks++;
      if (virt_fn_power_state_vec !== vf_exp) begin
        n_errors++;
        $display("[ERR] vf state expected %h seen %h", vf_exp, virt_fn_power_state_vec);
      end
    end
    // Reset in mid-run must restore idle values while the inputs still hold random codes.
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    #1;
    chk("pf reset", 32'h0, {20'h0, func_power_state});
    chk("link reset", 32'h0, {28'h0, phy_link_status, link_power_state});
    chk("irq reset", 32'h0, {31'h0, irq});
    @(posedge aclk);
    aresetn <= 1'b1;
    give_verdict();
  end
endmodule
`default_nettype wire
